// ===== rtl/sfr_params.svh
// Constants of the serial flash read front end: opcodes, beat counts, enables, defaults.
// Included by the latency map and read engine files of the block; holds definitions only.
`ifndef SFR_PARAMS_SVH
`define SFR_PARAMS_SVH

// ==========================================================================
// Array and opcodes
// ==========================================================================
`define SFR_ARRAY_AW       27
`define SFR_OP_FAST        8'h0B
`define SFR_OP_FAST_LONG   8'h0C
`define SFR_OP_QUAD        8'hEB
`define SFR_OP_QUAD_LONG   8'hEC
`define SFR_OP_DDR         8'hED
`define SFR_OP_DDR_LONG    8'hEE
`define SFR_MODE_CONT      4'hA

// ==========================================================================
// Beat counts per phase
// ==========================================================================
`define SFR_BEATS_S3       6'h18
`define SFR_BEATS_S4       6'h20
`define SFR_BEATS_Q3       6'h06
`define SFR_BEATS_Q4       6'h08
`define SFR_OPC_LAST_SPI   6'h07
`define SFR_OPC_LAST_QPI   6'h01
`define SFR_MODE_LAST      6'h01
`define SFR_PRE_CYCLES     5'h04

// ==========================================================================
// Output enables, active low per I/O line
// ==========================================================================
`define SFR_OE_NONE        8'hFF
`define SFR_OE_ALL         8'h00
`define SFR_OE_SINGLE      8'hDD

// ==========================================================================
// Latency lookup default and clock figures in MHz
// ==========================================================================
`define SFR_LAT_DEFAULT    128'h0F0E0D0C0B0A09080706050403020100
`define SFR_SYS_CLK_MHZ    50
`define SFR_SCK_MAX_SDR_MHZ 133
`define SFR_SCK_MAX_DDR_MHZ 102

`endif

// ===== rtl/sfr_pkg.sv
// Types of the serial flash read front end.
// Assumes nothing beyond a SystemVerilog elaborator.
package sfr_pkg;

    // ======================================================================
    // States and read types
    // ======================================================================
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_OPC  = 3'h1,
        ST_ADDR = 3'h3,
        ST_MODE = 3'h2,
        ST_LAT  = 3'h6,
        ST_DATA = 3'h7,
        ST_SKIP = 3'h5
    } sfr_state_t;

    typedef enum logic [1:0] {
        RT_SINGLE = 2'h0,
        RT_QUAD   = 2'h1,
        RT_DDR    = 2'h2
    } sfr_rtype_t;

    // ======================================================================
    // Carriers
    // ======================================================================
    // Fields of volatile_config_two and volatile_config_one used by reads.
    typedef struct packed {
        logic       addrLong;
        logic       quadCmd;
        logic       quadEn;
        logic       preEn;
        logic [3:0] latCode;
        logic [7:0] preamble;
    } sfr_cfg_t;

    typedef struct packed {
        logic       sck;
        logic       csN;
        logic [7:0] io;
    } sfr_pins_t;

    typedef struct packed {
        logic [7:0] io;
        logic [7:0] oeN;
    } sfr_drive_t;

endpackage : sfr_pkg

// ===== rtl/sfr_latency_map.sv
// Latency lookup: latency code and read type to latency cycle count.
// Assumes the read type is stable while the count is loaded.
`timescale 1ns/10ps
`include "sfr_params.svh"

module sfr_latency_map #(
    parameter logic [127:0] SINGLE_MAP = `SFR_LAT_DEFAULT, // Byte per code, code 0 lowest.
    parameter logic [127:0] QUAD_MAP   = `SFR_LAT_DEFAULT, // Byte per code, code 0 lowest.
    parameter logic [127:0] DDR_MAP    = `SFR_LAT_DEFAULT  // Byte per code, code 0 lowest.
) (
    input  wire sfr_pkg::sfr_rtype_t readType,  // Read type of the command.
    input  wire logic [3:0]          latCode,   // Latency code field.
    output logic [4:0]               latCycles  // Latency cycles for this code.
);

    logic [4:0] singleTab [16];
    logic [4:0] quadTab   [16];
    logic [4:0] ddrTab    [16];

    // ======================================================================
    // Table unpacking
    // ======================================================================
    for (genvar i = 0; i < 16; i++) begin : g_entry
        if (SINGLE_MAP[i*8 +: 8] > 8'h1F || QUAD_MAP[i*8 +: 8] > 8'h1F || DDR_MAP[i*8 +: 8] > 8'h1F) begin : g_bad
            $error("sfr_latency_map: a latency entry exceeds 31 cycles.");
        end
        assign singleTab[i] = SINGLE_MAP[i*8 +: 5];
        assign quadTab[i]   = QUAD_MAP[i*8 +: 5];
        assign ddrTab[i]    = DDR_MAP[i*8 +: 5];
    end

    always_comb begin
        unique case (readType)
            sfr_pkg::RT_QUAD: begin
                latCycles = quadTab[latCode];
            end
            sfr_pkg::RT_DDR: begin
                latCycles = ddrTab[latCode];
            end
            default: begin
                latCycles = singleTab[latCode];
            end
        endcase
    end

endmodule : sfr_latency_map

// ===== rtl/sfr_read_engine.sv
// Read-command front end of a serial NOR flash: fast single-width, quad and DDR quad reads.
// Assumes serial clock, chip select and I/O levels are synchronous to sys_clk, and that
// the serial clock is slow enough that each of its levels lasts at least one sys_clk period.
//
// Overview of operation
// - 0Bh address length per select bit; 0Ch four bytes.
// - Fast read waits configured latency before data.
// - Fast read data on the two single lines.
// - Address increments per byte, wraps to zero.
// - EBh address length per select bit; ECh four bytes.
// - Quad reads served only with quad enable set.
// - Quad data byte-wide, changing on falling edges.
// - Mode Axh keeps quad continuous read mode.
// - Other mode byte or mode reset leaves it.
// - Quad command protocol: opcode four bits per rise.
// - DDR address, mode and data on both edges; opcode on rises.
// - Complementary mode nibbles arm DDR continuous mode.
// - Other nibbles or mode reset leave it.
// - Preamble fills four cycles before DDR data.
// - Programmable preamble, MSB first, on all lines.
// - DDR opcode four bits per rise in quad protocol.
// - Latency counted fall to fall; zero means immediate.
// - Chip select high ends any read.
`timescale 1ns/10ps
`include "sfr_params.svh"

module sfr_read_engine #(
    parameter int ARRAY_AW = `SFR_ARRAY_AW // Address bits of the array.
) (
    input  wire logic                sys_clk,     // System clock.
    input  wire logic                rst,         // Synchronous reset, active high.
    input  wire sfr_pkg::sfr_pins_t  pinIn,       // Serial clock, chip select, I/O levels.
    input  wire sfr_pkg::sfr_cfg_t   cfg,         // Volatile configuration fields.
    input  wire logic                modeReset,   // Mode reset command seen, pulse.
    input  wire logic [7:0]          arrayData,   // Array byte at arrayAddr.
    output logic [ARRAY_AW-1:0]      arrayAddr,   // Current read address.
    output sfr_pkg::sfr_drive_t      ioDrive,     // I/O levels and active-low enables.
    output logic                     contMode,    // Instruction-less reads armed.
    output logic                     otherCmd,    // Frame holds a command not served here.
    output logic [7:0]               otherOpcode  // Opcode of that command.
);

    if (ARRAY_AW < 24 || ARRAY_AW > 32) begin : g_bad_aw
        $error("sfr_read_engine: ARRAY_AW must lie between 24 and 32.");
    end

    sfr_pkg::sfr_state_t state;
    sfr_pkg::sfr_rtype_t readType;
    sfr_pkg::sfr_rtype_t decType;
    logic                sckPrev;
    logic                csPrev;
    logic                sckRise;
    logic                sckFall;
    logic                csFall;
    logic                csRise;
    logic                isSingle;
    logic                isDdr;
    logic                capEv;
    logic                opcDone;
    logic                addrEnd;
    logic                dataEv;
    logic                preEv;
    logic                decRead;
    logic                decLong;
    logic                preOn;
    logic                preBit;
    logic                modeGot;
    logic                contPend;
    logic [1:0]          bitSel;
    logic [2:0]          preIdx;
    logic [4:0]          latCnt;
    logic [4:0]          latLut;
    logic [4:0]          latLoad;
    logic [5:0]          cnt;
    logic [5:0]          addrBeats;
    logic [5:0]          decBeats;
    logic [7:0]          opcReg;
    logic [7:0]          nextOpc;
    logic [7:0]          modeReg;
    logic [7:0]          nextMode;
    logic [7:0]          shByte;
    logic [31:0]         addrReg;
    logic [31:0]         nextAddr;
    logic [31:0]         loadAddr;
    logic [ARRAY_AW-1:0] addrInc;

    // ======================================================================
    // Pin edge detection
    // ======================================================================
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sckPrev <= 1'b0;
            csPrev  <= 1'b1;
        end else begin
            sckPrev <= pinIn.sck;
            csPrev  <= pinIn.csN;
        end
    end

    assign sckRise  = pinIn.sck & ~sckPrev & ~pinIn.csN;
    assign sckFall  = ~pinIn.sck & sckPrev & ~pinIn.csN;
    assign csFall   = ~pinIn.csN & csPrev;
    assign csRise   = pinIn.csN & ~csPrev;
    assign isSingle = (readType == sfr_pkg::RT_SINGLE);
    assign isDdr    = (readType == sfr_pkg::RT_DDR);
    // A DDR address opens on a rise, so the fall after the last opcode bit carries no beat.
    assign capEv    = sckRise | (isDdr & sckFall & (cnt != 6'h00));

    // ======================================================================
    // Opcode decode
    // ======================================================================
    assign nextOpc = cfg.quadCmd ? {opcReg[3:0], pinIn.io[3:0]} : {opcReg[6:0], pinIn.io[0]};
    assign opcDone = (state == sfr_pkg::ST_OPC) && sckRise
                     && (cnt == (cfg.quadCmd ? `SFR_OPC_LAST_QPI : `SFR_OPC_LAST_SPI));

    always_comb begin
        decRead = 1'b1;
        decLong = cfg.addrLong;
        decType = sfr_pkg::RT_SINGLE;
        unique case (nextOpc)
            `SFR_OP_FAST: begin
                decLong = cfg.addrLong;
            end
            `SFR_OP_FAST_LONG: begin
                decLong = 1'b1;
            end
            `SFR_OP_QUAD: begin
                decType = sfr_pkg::RT_QUAD;
            end
            `SFR_OP_QUAD_LONG: begin
                decType = sfr_pkg::RT_QUAD;
                decLong = 1'b1;
            end
            `SFR_OP_DDR: begin
                decType = sfr_pkg::RT_DDR;
            end
            `SFR_OP_DDR_LONG: begin
                decType = sfr_pkg::RT_DDR;
                decLong = 1'b1;
            end
            default: begin
                decRead = 1'b0;
            end
        endcase
        if (decType != sfr_pkg::RT_SINGLE && !cfg.quadEn) begin
            decRead = 1'b0;
        end
        if (decType == sfr_pkg::RT_SINGLE) begin
            decBeats = decLong ? `SFR_BEATS_S4 : `SFR_BEATS_S3;
        end else begin
            decBeats = decLong ? `SFR_BEATS_Q4 : `SFR_BEATS_Q3;
        end
    end

    // ======================================================================
    // Latency lookup
    // ======================================================================
    sfr_latency_map u_lat (
        .readType  (readType),
        .latCode   (cfg.latCode),
        .latCycles (latLut)
    );

    // The mode end of a DDR read is itself a falling edge, so one latency cycle is already spent there.
    assign latLoad = (isDdr && latLut != 5'h00) ? latLut - 5'h01 : latLut;

    // ======================================================================
    // Command sequencer
    // ======================================================================
    assign addrEnd = (state == sfr_pkg::ST_ADDR) && capEv && (cnt == addrBeats - 6'h01);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state       <= sfr_pkg::ST_IDLE;
            readType    <= sfr_pkg::RT_SINGLE;
            cnt         <= 6'h00;
            addrBeats   <= `SFR_BEATS_S3;
            latCnt      <= 5'h00;
            otherCmd    <= 1'b0;
            otherOpcode <= 8'h00;
        end else if (pinIn.csN) begin
            state <= sfr_pkg::ST_IDLE;
        end else begin
            unique case (state)
                sfr_pkg::ST_IDLE: begin
                    if (csFall) begin
                        cnt      <= 6'h00;
                        otherCmd <= 1'b0;
                        state    <= contMode ? sfr_pkg::ST_ADDR : sfr_pkg::ST_OPC;
                    end
                end
                sfr_pkg::ST_OPC: begin
                    if (opcDone) begin
                        cnt <= 6'h00;
                        if (decRead) begin
                            state     <= sfr_pkg::ST_ADDR;
                            readType  <= decType;
                            addrBeats <= decBeats;
                        end else begin
                            state       <= sfr_pkg::ST_SKIP;
                            otherCmd    <= 1'b1;
                            otherOpcode <= nextOpc;
                        end
                    end else if (sckRise) begin
                        cnt <= cnt + 6'h01;
                    end
                end
                sfr_pkg::ST_ADDR: begin
                    if (addrEnd) begin
                        cnt    <= 6'h00;
                        latCnt <= latLoad;
                        state  <= isSingle ? sfr_pkg::ST_LAT : sfr_pkg::ST_MODE;
                    end else if (capEv) begin
                        cnt <= cnt + 6'h01;
                    end
                end
                sfr_pkg::ST_MODE: begin
                    if (capEv && cnt == `SFR_MODE_LAST) begin
                        state <= sfr_pkg::ST_LAT;
                    end else if (capEv) begin
                        cnt <= cnt + 6'h01;
                    end
                end
                sfr_pkg::ST_LAT: begin
                    if (sckFall && latCnt == 5'h00) begin
                        state <= sfr_pkg::ST_DATA;
                    end else if (sckFall) begin
                        latCnt <= latCnt - 5'h01;
                    end
                end
                sfr_pkg::ST_DATA, sfr_pkg::ST_SKIP: begin
                    state <= state;
                end
                default: begin
                    state <= sfr_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ======================================================================
    // Opcode, address and mode shifters
    // ======================================================================
    assign nextAddr = isSingle ? {addrReg[30:0], pinIn.io[0]} : {addrReg[27:0], pinIn.io[3:0]};
    assign nextMode = {modeReg[3:0], pinIn.io[3:0]};
    assign loadAddr = (addrBeats == `SFR_BEATS_S3 || addrBeats == `SFR_BEATS_Q3)
                      ? {8'h00, nextAddr[23:0]} : nextAddr;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            opcReg  <= 8'h00;
            addrReg <= 32'h0000_0000;
            modeReg <= 8'h00;
        end else begin
            if (state == sfr_pkg::ST_OPC && sckRise) begin
                opcReg <= nextOpc;
            end
            if (state == sfr_pkg::ST_ADDR && capEv) begin
                addrReg <= nextAddr;
            end
            if (state == sfr_pkg::ST_MODE && capEv) begin
                modeReg <= nextMode;
            end
        end
    end

    // ======================================================================
    // Continuous read mode
    // ======================================================================
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            modeGot  <= 1'b0;
            contPend <= 1'b0;
            contMode <= 1'b0;
        end else begin
            if (state == sfr_pkg::ST_MODE && capEv && cnt == `SFR_MODE_LAST) begin
                modeGot  <= 1'b1;
                contPend <= isDdr ? (nextMode[7:4] == ~nextMode[3:0])
                                  : (nextMode[7:4] == `SFR_MODE_CONT);
            end else if (csFall) begin
                modeGot <= 1'b0;
            end
            // A frame cut short before its mode byte leaves the mode untouched.
            if (csRise && modeGot) begin
                contMode <= contPend;
            end else if (modeReset) begin
                contMode <= 1'b0;
            end
        end
    end

    // ======================================================================
    // Address counter
    // ======================================================================
    assign addrInc = arrayAddr + ARRAY_AW'(1);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            arrayAddr <= '0;
        end else if (addrEnd) begin
            arrayAddr <= loadAddr[ARRAY_AW-1:0];
        end else if (dataEv && (!isSingle || bitSel == 2'h0)) begin
            arrayAddr <= addrInc;
        end
    end

    // ======================================================================
    // Output drive: preamble and data
    // ======================================================================
    assign dataEv = (state == sfr_pkg::ST_LAT && sckFall && latCnt == 5'h00)
                    || (state == sfr_pkg::ST_DATA && (sckFall || (isDdr && sckRise)));
    assign preEv  = state == sfr_pkg::ST_LAT && isDdr && cfg.preEn
                    && ((sckFall && latCnt != 5'h00 && latCnt <= `SFR_PRE_CYCLES) || (sckRise && preOn));
    assign preBit = cfg.preamble[preIdx];

    always_ff @(posedge sys_clk) begin
        if (rst || pinIn.csN) begin
            ioDrive.io  <= 8'h00;
            ioDrive.oeN <= `SFR_OE_NONE;
            bitSel      <= 2'h0;
            shByte      <= 8'h00;
            preIdx      <= 3'h7;
            preOn       <= 1'b0;
        end else if (preEv) begin
            ioDrive.io  <= {8{preBit}};
            ioDrive.oeN <= `SFR_OE_ALL;
            preIdx      <= preIdx - 3'h1;
            preOn       <= 1'b1;
        end else if (dataEv && !isSingle) begin
            ioDrive.io  <= arrayData;
            ioDrive.oeN <= `SFR_OE_ALL;
        end else if (dataEv) begin
            // Each fall carries two bits, MSB pair first: upper line takes the higher bit.
            ioDrive.oeN <= `SFR_OE_SINGLE;
            if (bitSel == 2'h0) begin
                ioDrive.io <= {2'h0, arrayData[7], 3'h0, arrayData[6], 1'b0};
                shByte     <= {arrayData[5:0], 2'h0};
            end else begin
                ioDrive.io <= {2'h0, shByte[7], 3'h0, shByte[6], 1'b0};
                shByte     <= {shByte[5:0], 2'h0};
            end
            bitSel <= bitSel + 2'h1;
        end
    end

    // ======================================================================
    // Assertions
    // ======================================================================
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_csHeld;
        pinIn.csN ##1 pinIn.csN;
    endsequence

    sequence s_lastLat;
        state == sfr_pkg::ST_LAT && sckFall && latCnt == 5'h00;
    endsequence

    a_release_on_cs: assert property (s_csHeld |-> ioDrive.oeN == `SFR_OE_NONE)
        else $error("I/O lines still driven with chip select high.");

    a_single_lines: assert property (state == sfr_pkg::ST_DATA && isSingle |-> ioDrive.oeN == `SFR_OE_SINGLE)
        else $error("Single-width data not on the two single lines.");

    a_quad_lines: assert property (state == sfr_pkg::ST_DATA && !isSingle |-> ioDrive.oeN == `SFR_OE_ALL)
        else $error("Quad data not on all eight lines.");

    a_addr_step: assert property (dataEv && !isSingle |=> arrayAddr == $past(addrInc))
        else $error("Address did not step by one after a byte.");

    a_quad_gate: assert property (opcDone && decType != sfr_pkg::RT_SINGLE && !cfg.quadEn |=> state == sfr_pkg::ST_SKIP)
        else $error("Quad read served with quad enable clear.");

    a_cont_entry: assert property (csFall && contMode |=> state == sfr_pkg::ST_ADDR)
        else $error("Continuous mode frame did not start at the address.");

    a_mode_clear: assert property (modeReset && !(csRise && modeGot) |=> !contMode)
        else $error("Mode reset did not leave continuous mode.");

    a_lat_zero: assert property (s_lastLat |=> state == sfr_pkg::ST_DATA && ioDrive.oeN != `SFR_OE_NONE)
        else $error("Data did not start at the last latency fall.");

    a_preamble_bit: assert property (preEv |=> ioDrive.io == {8{$past(preBit)}} && ioDrive.oeN == `SFR_OE_ALL)
        else $error("Preamble bit not driven on every line.");

    a_long_addr: assert property (opcDone && decRead && nextOpc == `SFR_OP_FAST_LONG |=> addrBeats == `SFR_BEATS_S4)
        else $error("Long-address fast read not given four address bytes.");

endmodule : sfr_read_engine

// ===== verif/sfr_host_model.sv
// Host controller model: drives serial clock, chip select and I/O lines.
// Assumes the engine samples the pins on sys_clk and answers on its drive port.
`timescale 1ns/10ps
module sfr_host_model (
    input  wire logic                sys_clk, // System clock.
    input  wire sfr_pkg::sfr_drive_t dIn,     // Engine drive.
    output sfr_pkg::sfr_pins_t       pins     // Pins seen by the engine.
);
    logic                sck  = 1'b0;
    logic                csN  = 1'b1;
    logic                drv  = 1'b1;
    logic [3:0]          hIo  = 4'h0;
    logic [7:0]          junk = 8'h00;
    sfr_pkg::sfr_drive_t seen;
    // Released lines toggle so that a stale level never looks valid.
    always @(posedge sys_clk) junk <= ~junk;
    assign pins = {sck, csN, drv ? {4'h0, hIo} : junk};
    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : wt
    // One serial clock of 80 ns; lines are released from the fall on.
    task automatic cyc(input logic [3:0] n, input logic d);
        sck <= 1'b0;
        hIo <= n;
        drv <= d;
        wt(2);
        seen = dIn;
        sck <= 1'b1;
        wt(2);
    endtask : cyc
    // One serial clock edge per call, two sys_clk apart; the nibble is set up a cycle before it.
    task automatic hedge(input logic [3:0] n, input logic d);
        hIo <= n;
        drv <= d;
        wt(1);
        seen = dIn;
        sck <= ~sck;
        wt(1);
    endtask : hedge
    task automatic send(input logic [31:0] v, input int cnt, input int w);
        for (int i = cnt - 1; i >= 0; i--) cyc(4'(v >> (i * w)) & (w == 1 ? 4'h1 : 4'hF), 1'b1);
    endtask : send
    task automatic rd(input int w, output logic [7:0] b, output logic [7:0] oe);
        b = 8'h00;
        for (int i = 0; i < (w == 1 ? 4 : 1); i++) begin
            cyc(4'h0, 1'b0);
            b = (w == 1) ? {b[5:0], seen.io[5], seen.io[1]} : seen.io;
        end
        oe = seen.oeN;
    endtask : rd
    task automatic start();
        csN <= 1'b0;
        wt(2);
    endtask : start
    // Chip select rises only after data or in a refused frame, never in mode or latency.
    task automatic stop();
        csN <= 1'b1;
        wt(2);
        sck <= 1'b0;
        wt(2);
    endtask : stop
endmodule : sfr_host_model

// ===== verif/test_sfr_read_engine.sv
// Bench of the read engine: fast, quad, continuous and refused reads.
// Assumes the host model and an address-derived byte pattern as the array.
`timescale 1ns/10ps
module test_sfr_read_engine;
    logic                sys_clk   = 1'b0;
    logic                rst       = 1'b1;
    sfr_pkg::sfr_cfg_t   cfg       = '0;
    sfr_pkg::sfr_pins_t  pins;
    sfr_pkg::sfr_drive_t ioDrive;
    logic [23:0]         addr;
    logic [7:0]          arrayData;
    logic                contMode;
    logic                otherCmd;
    logic [7:0]          otherOpcode;
    logic                modeReset   = 1'b0;
    logic [7:0]          b;
    logic [7:0]          oe;
    int                  miscompares = 0;
    int                  compares    = 0;
    assign arrayData = addr[7:0] ^ 8'h5A;
    initial forever #10 sys_clk = ~sys_clk;
    sfr_host_model HOST (.sys_clk(sys_clk), .dIn(ioDrive), .pins(pins));
    sfr_read_engine #(.ARRAY_AW(24)) DUT (.sys_clk(sys_clk), .rst(rst), .pinIn(pins), .cfg(cfg),
        .modeReset(modeReset), .arrayData(arrayData), .arrayAddr(addr), .ioDrive(ioDrive),
        .contMode(contMode), .otherCmd(otherCmd), .otherOpcode(otherOpcode));
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic final_report();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : final_report
    task automatic t_fast(input logic [7:0] op, input int n);
        cfg.latCode <= 4'h2;
        HOST.start();
        HOST.send({24'h0, op}, 8, 1);
        HOST.send(32'h00000010, n, 1);
        repeat (2) HOST.cyc(4'h0, 1'b0);
        HOST.rd(1, b, oe);
        chk("fast byte0", 8'h4A, b);
        chk("fast oe", 8'hDD, oe);
        HOST.rd(1, b, oe);
        chk("fast byte1", 8'h4B, b);
        HOST.stop();
    endtask : t_fast
    task automatic qfr(input logic op, input logic [23:0] a, input logic [7:0] m, input logic c);
        cfg.quadEn  <= 1'b1;
        cfg.quadCmd <= 1'b0;
        cfg.latCode <= 4'h1;
        HOST.start();
        if (op) HOST.send(32'h000000EB, 8, 1);
        HOST.send({8'h00, a}, 6, 4);
        HOST.send({24'h0, m}, 2, 4);
        HOST.cyc(4'h0, 1'b0);
        HOST.rd(4, b, oe);
        chk("quad byte0", a[7:0] ^ 8'h5A, b);
        chk("quad oe", 8'h00, oe);
        HOST.rd(4, b, oe);
        chk("quad byte1", 8'(a + 24'h1) ^ 8'h5A, b);
        HOST.stop();
        chk("cont mode", {7'h0, c}, {7'h0, contMode});
    endtask : qfr
    task automatic ddr(input logic op, input logic [31:0] a, input logic [7:0] m, input logic c);
        logic [7:0] pat = 8'h34;
        cfg.quadEn   <= 1'b1;
        cfg.quadCmd  <= 1'b1;
        cfg.preEn    <= 1'b1;
        cfg.preamble <= pat;
        cfg.latCode  <= 4'h5;
        HOST.start();
        if (op) HOST.send(32'h000000EE, 2, 4);
        if (op) HOST.hedge(4'h0, 1'b1);
        for (int i = 7; i >= 0; i--) HOST.hedge(4'(a >> (i * 4)), 1'b1);
        HOST.hedge(m[7:4], 1'b1);
        HOST.hedge(m[3:0], 1'b1);
        for (int i = 1; i <= 12; i++) begin
            HOST.hedge(4'h0, 1'b0);
            if (i > 2 && i < 11) chk("preamble", {8{pat[10 - i]}}, HOST.seen.io);
            if (i > 10) chk("ddr data", 8'(a + 32'(i - 11)) ^ 8'h5A, HOST.seen.io);
        end
        HOST.stop();
        chk("ddr cont", {7'h0, c}, {7'h0, contMode});
    endtask : ddr
    task automatic t_mreset();
        modeReset <= 1'b1;
        @(posedge sys_clk);
        modeReset <= 1'b0;
        @(posedge sys_clk);
        chk("mode reset", 8'h00, {7'h0, contMode});
    endtask : t_mreset
    task automatic t_refuse(input logic q, input logic [7:0] op);
        cfg.quadCmd <= q;
        cfg.quadEn  <= 1'b0;
        HOST.start();
        if (q) HOST.send({24'h0, op}, 2, 4);
        else HOST.send({24'h0, op}, 8, 1);
        HOST.send(32'h00000000, 24, 1);
        HOST.rd(4, b, oe);
        chk("other op", op, otherOpcode);
        chk("other flag", 8'h01, {7'h0, otherCmd});
        chk("refused oe", 8'hFF, oe);
        HOST.stop();
    endtask : t_refuse
    initial begin
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        chk("reset oe", 8'hFF, ioDrive.oeN);
        t_fast(8'h0B, 24);
        t_fast(8'h0C, 32);
        qfr(1'b1, 24'hFFFFFF, 8'hA3, 1'b1);
        qfr(1'b0, 24'h000020, 8'h50, 1'b0);
        ddr(1'b1, 32'h00000040, 8'h5A, 1'b1);
        ddr(1'b0, 32'h12345678, 8'h00, 1'b0);
        qfr(1'b1, 24'h000030, 8'hA0, 1'b1);
        t_mreset();
        t_refuse(1'b1, 8'hEB);
        t_refuse(1'b0, 8'h03);
        final_report();
    end
    initial begin
        #100us;
        miscompares++;
        final_report();
    end
endmodule : test_sfr_read_engine
